// [hdl/dif_pkg.sv]
package dif_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] DIF_IDX_TAP_LOW = 8'h5e;
    localparam logic [7:0] DIF_IDX_DLY_CTRL = 8'h5f;
    localparam logic [7:0] DIF_IDX_CFG_A = 8'h79;
    localparam logic [7:0] DIF_IDX_REVISION = 8'h7f;
    localparam logic [7:0] DIF_IDX_CFG_B = 8'h80;
    localparam logic [7:0] DIF_IDX_CFG_C = 8'he1;
    localparam logic [7:0] DIF_IDX_FIFO_DEPTH = 8'h90;
    localparam logic [7:0] DIF_IDX_FIFO_STATUS = 8'h91;
    localparam logic [7:0] DIF_IDX_CLK_CTRL = 8'h92;

    // Reset values
    localparam logic [7:0] DIF_RST_TAP_LOW = 8'hff;
    localparam logic [7:0] DIF_RST_DLY_CTRL = 8'h07;
    localparam logic [7:0] DIF_RST_CFG = 8'h00;
    localparam logic [2:0] DIF_RST_FIFO_DEPTH = 3'h4;
    localparam logic [7:0] DIF_RST_CLK_CTRL = 8'h00;

    // Field positions in the delay control register
    localparam int DIF_POS_DLY_EN = 3;
    localparam int DIF_POS_TAP_SEL_LO = 0;

    // Decoded delay line taps
    localparam logic [10:0] DIF_TAP_CODE0 = 11'h000;
    localparam logic [10:0] DIF_TAP_CODE1 = 11'h007;
    localparam logic [10:0] DIF_TAP_CODE2 = 11'h07f;
    localparam logic [10:0] DIF_TAP_CODE3 = 11'h5ff;

    // FIFO geometry and synchroniser depth
    localparam int DIF_FIFO_SLOTS = 8;
    localparam int DIF_PTR_W = 3;
    localparam int DIF_SYNC_STAGES = 2;

    // Bus request carried as one bundle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] index;
        logic [7:0] wdata;
    } dif_req_t;

    // FIFO pointer snapshot
    typedef struct packed {
        logic [2:0] wr_ptr;
        logic [2:0] rd_ptr;
    } dif_ptrs_t;

    // Slots from the read pointer up to the write pointer, modulo eight
    function automatic logic [2:0] dif_gap(input logic [2:0] wr, input logic [2:0] rd);
        dif_gap = 3'(wr - rd);
    endfunction

endpackage

// [hdl/dif_clk_div.sv]
`timescale 1ns/1ps
`default_nettype none
module dif_clk_div
    import dif_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic force_phase,
    input wire logic forced_value,
    output logic phase
);

    // Halving divider; the read side runs on its high phase only
    // phase settable
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= 1'b0;
        end else if (force_phase) begin
            phase <= forced_value;
        end else begin
            phase <= ~phase;
        end
    end

endmodule
`default_nettype wire

// [hdl/dif_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module dif_fifo
    import dif_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic wr_side_reset,
    input wire logic rd_side_reset,
    input wire logic [2:0] depth,
    output logic [DATA_W-1:0] rd_data,
    output dif_ptrs_t ptrs
);

    // Eight slots; no full or empty, the pointers simply circulate
    logic [DATA_W-1:0] slots [DIF_FIFO_SLOTS];
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    // Placement targets used by the two side resets
    wire logic [2:0] next_wr_place = 3'(rd_ptr + depth);
    wire logic [2:0] next_rd_place = 3'(wr_ptr - depth);

    assign ptrs = '{wr_ptr: wr_ptr, rd_ptr: rd_ptr};

    // Slot storage, written at the write pointer
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            slots[wr_ptr] <= wr_data;
        end
    end

    // Write pointer; a write side reset lands it depth slots ahead
    // wraps through slots
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= 3'h0;
        end else if (wr_side_reset) begin
            wr_ptr <= next_wr_place;
        end else if (wr_en) begin
            wr_ptr <= 3'(wr_ptr + 3'h1);
        end
    end

    // Read pointer; a read side reset lands it depth slots behind
    // depth behind writer
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_ptr <= 3'h0;
        end else if (rd_side_reset) begin
            rd_ptr <= next_rd_place;
        end else if (rd_en) begin
            rd_ptr <= 3'(rd_ptr + 3'h1);
        end
    end

    // Read data register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= slots[rd_ptr];
        end
    end

endmodule
`default_nettype wire

// [hdl/dif_input_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module dif_input_fifo
    import dif_pkg::*;
#(
    parameter int DATA_W = 16,
    // Arbitrary neutral revision value
    parameter logic [7:0] REVISION_CODE = 8'h3c
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic data_clock_input,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic frame_ref,
    input wire logic sync_ref,
    output logic [DATA_W-1:0] dac_data,
    output logic dac_data_valid,
    output logic filter_clk_phase,
    output logic [10:0] delay_tap_value,
    output logic delay_line_enable
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [7:0] rx_delay_tap_low; // Low byte of the tap, kept for readback
    logic [7:0] rx_delay_control; // Enable and tap select
    logic [7:0] startup_config_a; // Start-up setting a
    logic [7:0] startup_config_b; // Start-up setting b
    logic [7:0] startup_config_c; // Start-up setting c
    logic [2:0] fifo_depth_setting; // Depth to restore on a FIFO reset
    logic [7:0] clock_control; // Bit 0 force phase, bit 1 forced value
    // Revision is a parameter, not storage, so a write to it falls away

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    // Only the low byte of write data is used; no register is wider than eight bits
    // Bundle the request; index is the word address
    wire dif_req_t req = '{rd: avs_read, wr: avs_write, index: avs_address[9:2],
                           wdata: avs_writedata[7:0]};
    // A request is served on the one cycle waitrequest is low
    wire logic accept = (req.rd | req.wr) & ~avs_waitrequest;
    wire logic wr_accept = accept & req.wr;
    wire logic hit_tap_low = wr_accept & (req.index == DIF_IDX_TAP_LOW);
    wire logic hit_dly_ctrl = wr_accept & (req.index == DIF_IDX_DLY_CTRL);
    wire logic hit_cfg_a = wr_accept & (req.index == DIF_IDX_CFG_A);
    wire logic hit_cfg_b = wr_accept & (req.index == DIF_IDX_CFG_B);
    wire logic hit_cfg_c = wr_accept & (req.index == DIF_IDX_CFG_C);
    wire logic hit_depth = wr_accept & (req.index == DIF_IDX_FIFO_DEPTH);
    wire logic hit_clk = wr_accept & (req.index == DIF_IDX_CLK_CTRL);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    // Two flops per pin; only the second stage is read by logic
    logic [DIF_SYNC_STAGES-1:0] dclk_sync;
    logic [DIF_SYNC_STAGES-1:0] frame_sync;
    logic [DIF_SYNC_STAGES-1:0] sync_sync;
    logic [DATA_W-1:0] data_meta;
    logic [DATA_W-1:0] data_sync;
    logic dclk_last; // Previous settled data clock level
    logic frame_last; // Previous settled frame level
    logic sync_last; // Previous settled sync level

    // Synchroniser chains.
    // The data word crosses bit by bit with no handshake, so the source
    // must hold it steady for a few converter clocks around each data clock rise.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dclk_sync <= '0;
            frame_sync <= '0;
            sync_sync <= '0;
            data_meta <= '0;
            data_sync <= '0;
        end else begin
            dclk_sync <= {dclk_sync[0], data_clock_input};
            frame_sync <= {frame_sync[0], frame_ref};
            sync_sync <= {sync_sync[0], sync_ref};
            data_meta <= data_in;
            data_sync <= data_meta;
        end
    end

    // Edge history taken from the settled stage only
    // Resets to the idle low level of each pin, so no false edge follows reset
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dclk_last <= 1'b0;
            frame_last <= 1'b0;
            sync_last <= 1'b0;
        end else begin
            dclk_last <= dclk_sync[1];
            frame_last <= frame_sync[1];
            sync_last <= sync_sync[1];
        end
    end

    wire logic dclk_rise = dclk_sync[1] & ~dclk_last;
    wire logic frame_rise = frame_sync[1] & ~frame_last;
    wire logic sync_rise = sync_sync[1] & ~sync_last;

    ////////////////////////////////////////////////////////////////////////////////
    // Delay line decode

    // Only two select bits are decoded; bit 2 is kept for readback
    // tap code decode
    wire logic [1:0] tap_select = rx_delay_control[DIF_POS_TAP_SEL_LO +: 2];
    wire logic [10:0] next_tap = (tap_select == 2'h0) ? DIF_TAP_CODE0 :
                                 (tap_select == 2'h1) ? DIF_TAP_CODE1 :
                                 (tap_select == 2'h2) ? DIF_TAP_CODE2 : DIF_TAP_CODE3;
    wire logic dly_en = rx_delay_control[DIF_POS_DLY_EN];

    ////////////////////////////////////////////////////////////////////////////////
    // FIFO and divider

    logic phase; // Halved converter clock
    logic [DATA_W-1:0] fifo_out; // Word last read from the FIFO
    dif_ptrs_t ptrs; // Live pointer pair

    wire logic fifo_wr = dclk_rise & dly_en;
    // Reads never pause; with no full or empty flag a rate mismatch just wraps
    // read on halved clock
    wire logic fifo_rd = phase;
    wire logic wr_side_reset = frame_rise;
    wire logic rd_side_reset = sync_rise;

    // Forcing the phase the divider already holds stretches one halved cycle
    // phase forced on sync
    wire logic force_phase = clock_control[0] & sync_rise;

    dif_clk_div u_div (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .force_phase(force_phase),
        .forced_value(clock_control[1]),
        .phase(phase)
    );

    // Side resets come from synchronised pins, so they act three edges late
    // latency equals depth
    dif_fifo #(
        .DATA_W(DATA_W)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr_en(fifo_wr),
        .wr_data(data_sync),
        .rd_en(fifo_rd),
        .wr_side_reset(wr_side_reset),
        .rd_side_reset(rd_side_reset),
        .depth(fifo_depth_setting),
        .rd_data(fifo_out),
        .ptrs(ptrs)
    );

    // The gap wraps modulo eight and drifts freely until a side reset
    // depth drifts until reset
    wire logic [2:0] live_depth = dif_gap(ptrs.wr_ptr, ptrs.rd_ptr);

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes

    // Delay registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_delay_tap_low <= DIF_RST_TAP_LOW;
            rx_delay_control <= DIF_RST_DLY_CTRL;
        end else begin
            if (hit_tap_low) begin
                rx_delay_tap_low <= req.wdata;
            end
            if (hit_dly_ctrl) begin
                // Upper bits are reserved and stay zero
                rx_delay_control <= {4'h0, req.wdata[3:0]};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            startup_config_a <= DIF_RST_CFG;
            startup_config_b <= DIF_RST_CFG;
            startup_config_c <= DIF_RST_CFG;
        end else begin
            if (hit_cfg_a) begin
                startup_config_a <= req.wdata;
            end
            if (hit_cfg_b) begin
                startup_config_b <= req.wdata;
            end
            if (hit_cfg_c) begin
                startup_config_c <= req.wdata;
            end
        end
    end

    // The setting acts only at the next frame or sync rise
    // depth preset to four
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fifo_depth_setting <= DIF_RST_FIFO_DEPTH;
        end else if (hit_depth && req.wdata[2:0] != 3'h0) begin
            // Zero would collide the pointers, so it is refused
            fifo_depth_setting <= req.wdata[2:0];
        end
    end

    // Clock control
    // Bit 0 arms a force at each sync rise; bit 1 is the phase to force
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            clock_control <= DIF_RST_CLK_CTRL;
        end else if (hit_clk) begin
            clock_control <= {6'h0, req.wdata[1:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux and handshake

    logic [7:0] next_rdata; // Selected read value

    // Status shows the write pointer and the live depth, to confirm the depth after a side reset
    // Unmapped reads return zero
    always_comb begin
        case (req.index)
            DIF_IDX_TAP_LOW: next_rdata = rx_delay_tap_low;
            DIF_IDX_DLY_CTRL: next_rdata = rx_delay_control;
            DIF_IDX_CFG_A: next_rdata = startup_config_a;
            DIF_IDX_REVISION: next_rdata = REVISION_CODE;
            DIF_IDX_CFG_B: next_rdata = startup_config_b;
            DIF_IDX_CFG_C: next_rdata = startup_config_c;
            DIF_IDX_FIFO_DEPTH: next_rdata = {5'h00, fifo_depth_setting};
            DIF_IDX_FIFO_STATUS: next_rdata = {2'h0, ptrs.wr_ptr, live_depth};
            DIF_IDX_CLK_CTRL: next_rdata = clock_control;
            default: next_rdata = 8'h00;
        endcase
    end

    // One wait cycle per request, then a single low cycle to complete it.
    // Costs a cycle per access but keeps the read mux off the output path.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if ((req.rd | req.wr) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= {24'h00_0000, next_rdata};
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output stage

    // Each word shows for two cycles; valid marks the second of them
    // Registered outputs toward the converter core
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dac_data <= '0;
            dac_data_valid <= 1'b0;
            filter_clk_phase <= 1'b0;
            delay_tap_value <= DIF_TAP_CODE3;
            delay_line_enable <= 1'b0;
        end else begin
            dac_data <= fifo_out;
            dac_data_valid <= fifo_rd;
            filter_clk_phase <= phase;
            delay_tap_value <= next_tap;
            delay_line_enable <= dly_en;
        end
    end

endmodule
`default_nettype wire

// [sim/dif_input_fifo_props.sv]
`timescale 1ns/1ps
`default_nettype none
module dif_input_fifo_props
    import dif_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter logic [7:0] REVISION_CODE = 8'h3c
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [DATA_W-1:0] dac_data,
    input wire logic dac_data_valid,
    input wire logic filter_clk_phase,
    input wire logic [10:0] delay_tap_value,
    input wire logic delay_line_enable
);
    // Register index and completing transfers
    wire logic [7:0] idx = avs_address[9:2];
    wire logic done_rd = avs_read && !avs_waitrequest;
    wire logic done_wr = avs_write && !avs_waitrequest;
    wire logic mapped = idx inside {8'h5e, 8'h5f, 8'h79, 8'h7f, 8'h80, 8'he1, 8'h90, 8'h91, 8'h92};
    logic [10:0] exp_tap; // Tap expected from the last control write
    logic exp_en; // Enable expected from the last control write
    function automatic logic [10:0] tap_of(input logic [1:0] c);
        case (c)
            2'h0: tap_of = DIF_TAP_CODE0;
            2'h1: tap_of = DIF_TAP_CODE1;
            2'h2: tap_of = DIF_TAP_CODE2;
            default: tap_of = DIF_TAP_CODE3;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////
    // Captured at the completing edge, since the master drops data after it
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            exp_tap <= DIF_TAP_CODE3;
            exp_en <= 1'b0;
        end else if (done_wr && idx == DIF_IDX_DLY_CTRL) begin
            exp_tap <= tap_of(avs_writedata[1:0]);
            exp_en <= avs_writedata[DIF_POS_DLY_EN];
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered next cycle");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_upper_zero: assert property (done_rd |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_rev_value: assert property (done_rd && idx == DIF_IDX_REVISION |->
        avs_readdata[7:0] == REVISION_CODE) else $error("revision value wrong");
    a_unmapped_zero: assert property (done_rd && !mapped |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_tap_decode: assert property (done_wr && idx == DIF_IDX_DLY_CTRL |->
        ##2 delay_tap_value == exp_tap) else $error("tap decode wrong");
    a_enable_bit: assert property (done_wr && idx == DIF_IDX_DLY_CTRL |->
        ##2 delay_line_enable == exp_en) else $error("delay enable wrong");
    a_valid_alternate: assert property (dac_data_valid |=> !dac_data_valid)
        else $error("valid on two cycles in a row");
    a_phase_runs: assert property (!filter_clk_phase [*2] |=> filter_clk_phase)
        else $error("halved clock stuck low");
endmodule
bind dif_input_fifo dif_input_fifo_props #(.DATA_W(DATA_W), .REVISION_CODE(REVISION_CODE)) i_props (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .dac_data(dac_data),
    .dac_data_valid(dac_data_valid),
    .filter_clk_phase(filter_clk_phase),
    .delay_tap_value(delay_tap_value),
    .delay_line_enable(delay_line_enable)
);
`default_nettype wire

// [sim/dif_src_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dif_src_model
    import dif_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic frame_req,
    input wire logic sync_req,
    output logic data_clock_input,
    output logic [DATA_W-1:0] data_in,
    output logic frame_ref,
    output logic sync_ref,
    output logic [15:0] sent
);
    ////////////////////////////////////////////////////////////////
    // Source clock rises every other cycle while running, stands low when idle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            data_clock_input <= 1'b0;
            data_in <= '0;
            sent <= 16'h0;
            frame_ref <= 1'b0;
            sync_ref <= 1'b0;
        end else begin
            // frame and sync references from outside
            frame_ref <= frame_req;
            sync_ref <= sync_req;
            if (data_clock_input) begin
                data_clock_input <= 1'b0;
                sent <= sent + 16'h1;
            end else if (run) begin
                data_clock_input <= 1'b1;
                data_in <= DATA_W'(sent + 16'h1000);
            end else begin
                // Idle data keeps moving so a stale word cannot pass
                data_in <= ~data_in;
            end
        end
    end
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dif_pkg::*;
    localparam logic [7:0] REV = 8'h3c; // Arbitrary revision value
    logic sys_clk, rst_b, avs_read, avs_write, avs_waitrequest, run, frame_req, sync_req;
    logic dclk, frame_ref, sync_ref, dac_data_valid, filter_clk_phase, delay_line_enable;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [15:0] data_in, dac_data, sent, la, lb;
    logic [10:0] delay_tap_value;
    int mismatches, compares, cycles;
    dif_input_fifo #(.DATA_W(16), .REVISION_CODE(REV)) i_dif_input_fifo (
        .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .data_clock_input(dclk), .data_in(data_in),
        .frame_ref(frame_ref), .sync_ref(sync_ref), .dac_data(dac_data),
        .dac_data_valid(dac_data_valid), .filter_clk_phase(filter_clk_phase),
        .delay_tap_value(delay_tap_value), .delay_line_enable(delay_line_enable));
    dif_src_model #(.DATA_W(16)) i_dif_src_model (
        .sys_clk(sys_clk), .rst_b(rst_b), .run(run), .frame_req(frame_req),
        .sync_req(sync_req), .data_clock_input(dclk), .data_in(data_in),
        .frame_ref(frame_ref), .sync_ref(sync_ref), .sent(sent));
    ////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic end_sim();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Watchdog; the whole run needs a few hundred cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("mismatch at %0t: timeout", $time);
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Bus tasks hold the request until waitrequest is sampled low
    task automatic bus_wr(input logic [7:0] idx, input logic [7:0] d);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_write <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        avs_address <= {idx, 2'b00};
        avs_read <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        chk({8'h0, avs_readdata[7:0]}, {8'h0, exp});
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs();
        chk({5'h0, delay_tap_value}, {5'h0, DIF_TAP_CODE3});
        chk({15'h0, delay_line_enable}, 16'h0);
        rd_chk(DIF_IDX_TAP_LOW, 8'hff);
        rd_chk(DIF_IDX_DLY_CTRL, 8'h07);
        rd_chk(DIF_IDX_CFG_A, 8'h00);
        rd_chk(DIF_IDX_CFG_B, 8'h00);
        rd_chk(DIF_IDX_CFG_C, 8'h00);
        rd_chk(DIF_IDX_FIFO_DEPTH, 8'h04);
        bus_wr(DIF_IDX_CFG_A, 8'h18);
        bus_wr(DIF_IDX_CFG_B, 8'had);
        bus_wr(DIF_IDX_CFG_C, 8'h1a);
        rd_chk(DIF_IDX_CFG_A, 8'h18);
        rd_chk(DIF_IDX_CFG_B, 8'had);
        rd_chk(DIF_IDX_CFG_C, 8'h1a);
        bus_wr(DIF_IDX_REVISION, ~REV);
        rd_chk(DIF_IDX_REVISION, REV);
        rd_chk(8'h01, 8'h00);
        // A zero depth would make latency undefined, so it is refused
        bus_wr(DIF_IDX_FIFO_DEPTH, 8'h00);
        rd_chk(DIF_IDX_FIFO_DEPTH, 8'h04);
        bus_wr(DIF_IDX_TAP_LOW, 8'h5a);
        rd_chk(DIF_IDX_TAP_LOW, 8'h5a);
    endtask
    // Every tap code, enable toggled alongside, reserved bits written high
    task automatic t_taps();
        logic [10:0] taps [4];
        logic [3:0] v;
        taps = '{DIF_TAP_CODE0, DIF_TAP_CODE1, DIF_TAP_CODE2, DIF_TAP_CODE3};
        for (int c = 0; c < 4; c++) begin
            v = {c[0], 1'b0, 2'(c)};
            bus_wr(DIF_IDX_DLY_CTRL, {4'hf, v});
            repeat (2) @(posedge sys_clk);
            chk({5'h0, delay_tap_value}, {5'h0, taps[c]});
            chk({15'h0, delay_line_enable}, {15'h0, c[0]});
            rd_chk(DIF_IDX_DLY_CTRL, {4'h0, v});
        end
        bus_wr(DIF_IDX_DLY_CTRL, 8'h0b);
    endtask
    ////////////////////////////////////////////////////////////////
    // Side reset issued at a fixed halved-clock phase so runs compare exactly
    task automatic side_reset(input logic [2:0] depth, input logic frame);
        bus_wr(DIF_IDX_FIFO_DEPTH, {5'h0, depth});
        do @(posedge sys_clk); while (filter_clk_phase !== 1'b1);
        frame_req <= frame;
        sync_req <= !frame;
        repeat (4) @(posedge sys_clk);
        frame_req <= 1'b0;
        sync_req <= 1'b0;
    endtask
    // Words in flight; consecutive outputs must also be consecutive words
    task automatic measure(output logic [15:0] lag);
        logic [15:0] w;
        repeat (40) @(posedge sys_clk);
        do @(posedge sys_clk); while (dac_data_valid !== 1'b1);
        w = dac_data;
        lag = sent - (w - 16'h1000);
        repeat (2) @(posedge sys_clk);
        chk({15'h0, dac_data_valid}, 16'h1);
        chk(dac_data, w + 16'h1);
    endtask
    task automatic t_latency();
        run <= 1'b1;
        side_reset(3'h4, 1'b0);
        measure(la);
        side_reset(3'h6, 1'b0);
        measure(lb);
        chk(lb - la, 16'h2);
        side_reset(3'h4, 1'b1);
        measure(la);
        side_reset(3'h2, 1'b1);
        measure(lb);
        chk(la - lb, 16'h2);
    endtask
    // Sync rise at a fixed phase, first free running, then with the force armed to low
    task automatic t_force();
        side_reset(3'h4, 1'b0);
        repeat (2) @(posedge sys_clk);
        chk({15'h0, filter_clk_phase}, 16'h1);
        bus_wr(DIF_IDX_CLK_CTRL, 8'h01);
        rd_chk(DIF_IDX_CLK_CTRL, 8'h01);
        side_reset(3'h4, 1'b0);
        repeat (2) @(posedge sys_clk);
        chk({15'h0, filter_clk_phase}, 16'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        run = 1'b0;
        frame_req = 1'b0;
        sync_req = 1'b0;
        mismatches = 0;
        compares = 0;
        cycles = 0;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_regs();
        t_taps();
        t_latency();
        t_force();
        end_sim();
    end
endmodule
`default_nettype wire
